// file: verilog/bwsd_regs.svh
`ifndef BWSD_REGS_SVH
`define BWSD_REGS_SVH
`define BWSD_ADDR_W 20
`define BWSD_TOP_ADDR 20'hFFFFF
`define BWSD_SITES 4
`define BWSD_XSITE_BYTES 20'h02000
`define BWSD_SEL_NONE 12'h000
`define BWSD_RAM_SHIFT_RST 3'h0
`define BWSD_ZERO_ADDR 20'h00000
`define BWSD_SIZE_2K 20'h00800
`define BWSD_SIZE_8K 20'h02000
`define BWSD_SIZE_16K 20'h04000
`define BWSD_SIZE_32K 20'h08000
`define BWSD_SIZE_64K 20'h10000
`endif

// file: verilog/bwsd_pkg.sv
package bwsd_pkg;
  // Part size in each program site; sets the bytes per site
  typedef enum logic [2:0] {
    BWSD_PART_2K = 3'b000,
    BWSD_PART_8K = 3'b001,
    BWSD_PART_16K = 3'b010,
    BWSD_PART_32K = 3'b011,
    BWSD_PART_64K = 3'b100
  } bwsd_part_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [19:0] addr;
  } bwsd_req_t;

  typedef struct packed {
    bwsd_part_t prog_part;
    logic [2:0] ram_part;
    logic ram_high;
    logic exp_fitted;
    logic protect;
  } bwsd_cfg_t;
endpackage

// file: verilog/bwsd_decode.sv
// What this block does
// - Eight sites: four program, four data
// - Program group top-justified in 1 MB
// - Program parts 2K, 8K, 16K, 32K, 64K
// - Data group starts at zero by default
// - Data group relocatable just below program
// - Expansion adds four sites above data, only while the data group is at zero
// - Protect input blocks all data accesses
`timescale 1ns/1ps
`include "bwsd_regs.svh"
module bwsd_decode
  import bwsd_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire bwsd_req_t req,
  input wire bwsd_cfg_t cfg,
  output logic [11:0] site_sel,
  output logic rd_strobe,
  output logic wr_strobe,
  output logic blocked,
  output logic unmapped
);
  // Bytes per site for each group
  logic [19:0] prog_size;
  logic [19:0] ram_size;

  // Each group spans four sites
  logic [19:0] prog_span;
  logic [19:0] ram_span;

  // Group bounds
  logic [19:0] prog_base;
  logic [19:0] ram_base;
  logic [19:0] ram_end;
  logic [19:0] exp_base;
  logic exp_live;

  // Configuration fields pulled out of the carrier
  logic [2:0] cfg_prog_part;
  logic [2:0] cfg_ram_part;
  logic cfg_ram_high;
  logic cfg_exp_fitted;
  logic cfg_protect;

  // Request fields pulled out of the carrier
  logic req_valid;
  logic req_write;
  logic [19:0] req_addr;

  // Decode results
  logic [11:0] site_hit;
  logic [3:0] prog_hit;
  logic [3:0] ram_hit;
  logic [3:0] exp_hit;
  logic in_prog;
  logic in_ram;
  logic in_exp;
  logic data_side;
  logic refuse;

  // Next register values
  logic [11:0] next_site_sel;
  logic next_rd_strobe;
  logic next_wr_strobe;
  logic next_blocked;
  logic next_unmapped;
  genvar gi;

  // Unused part codes fall back to the smallest part
  function automatic logic [19:0] bwsd_size(input logic [2:0] p);
    logic [19:0] s;
    s = `BWSD_SIZE_2K;
    case (p)
      3'b000: begin
        s = `BWSD_SIZE_2K;
      end
      3'b001: begin
        s = `BWSD_SIZE_8K;
      end
      3'b010: begin
        s = `BWSD_SIZE_16K;
      end
      3'b011: begin
        s = `BWSD_SIZE_32K;
      end
      3'b100: begin
        s = `BWSD_SIZE_64K;
      end
      default: begin
        s = `BWSD_SIZE_2K;
      end
    endcase
    return s;
  endfunction

  always_comb begin
    cfg_prog_part = cfg.prog_part;
    cfg_ram_part = cfg.ram_part;
    cfg_ram_high = cfg.ram_high;
    cfg_exp_fitted = cfg.exp_fitted;
    cfg_protect = cfg.protect;
  end

  always_comb begin
    req_valid = req.valid;
    req_write = req.write;
    req_addr = req.addr;
  end

  always_comb begin
    prog_size = bwsd_size(cfg_prog_part);
    ram_size = bwsd_size(cfg_ram_part);
    prog_span = 20'(prog_size << 2);
    ram_span = 20'(ram_size << 2);
    // Top-justified so the last byte of the space is the last program byte
    prog_base = 20'(`BWSD_TOP_ADDR - prog_span + 20'h00001);
    if (cfg_ram_high) begin
      // Flush under the program group so code can run on into it
      ram_base = 20'(prog_base - ram_span);
    end else begin
      ram_base = `BWSD_ZERO_ADDR;
    end
    ram_end = 20'(ram_base + ram_span);
    exp_base = ram_end;
    // Above a relocated data group there is no room left below program
    exp_live = cfg_exp_fitted && !cfg_ram_high;
  end

  // One range decoder per site; its group decides where the four start
  generate
    for (gi = 0; gi < 12; gi++) begin : g_site
      logic [19:0] base;
      logic [19:0] size;
      logic [19:0] off;
      logic live;
      if (gi < 4) begin : g_prog
        assign size = prog_size;
        assign base = 20'(prog_base + 20'(prog_size * (gi % 4)));
        assign live = 1'b1;
      end else if (gi < 8) begin : g_ram
        assign size = ram_size;
        assign base = 20'(ram_base + 20'(ram_size * (gi % 4)));
        assign live = 1'b1;
      end else begin : g_exp
        assign size = `BWSD_XSITE_BYTES;
        assign base = 20'(exp_base + 20'(`BWSD_XSITE_BYTES * (gi % 4)));
        assign live = exp_live;
      end
      // Below base the subtraction wraps past size, so one compare bounds both ends
      assign off = 20'(req_addr - base);
      assign site_hit[gi] = live && (off < size);
    end
  endgenerate

  always_comb begin
    prog_hit = site_hit[3:0];
    ram_hit = site_hit[7:4];
    exp_hit = site_hit[11:8];
    in_prog = |prog_hit;
    in_ram = |ram_hit;
    in_exp = |exp_hit;
    // Program wins any overlap, so the data side only counts below it
    data_side = !in_prog && (in_ram || in_exp);
    // Expansion parts hold data as well, so protect covers them too
    refuse = data_side && cfg_protect;
  end

  always_comb begin
    next_site_sel = `BWSD_SEL_NONE;
    if (req_valid) begin
      if (in_prog) begin
        next_site_sel[3:0] = prog_hit;
      end else if (refuse) begin
        // Battery-held contents must see no select while power falls
        next_site_sel = `BWSD_SEL_NONE;
      end else if (in_ram) begin
        next_site_sel[7:4] = ram_hit;
      end else if (in_exp) begin
        next_site_sel[11:8] = exp_hit;
      end
    end
  end

  always_comb begin
    next_rd_strobe = 1'b0;
    next_wr_strobe = 1'b0;
    next_blocked = 1'b0;
    next_unmapped = 1'b0;
    if (req_valid) begin
      if (refuse) begin
        next_blocked = 1'b1;
      end else if (!(in_prog || in_ram || in_exp)) begin
        next_unmapped = 1'b1;
      end else begin
        next_rd_strobe = !req_write;
        next_wr_strobe = req_write;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      site_sel <= `BWSD_SEL_NONE;
    end else begin
      site_sel <= next_site_sel;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_strobe <= 1'b0;
      wr_strobe <= 1'b0;
      blocked <= 1'b0;
      unmapped <= 1'b0;
    end else begin
      rd_strobe <= next_rd_strobe;
      wr_strobe <= next_wr_strobe;
      blocked <= next_blocked;
      unmapped <= next_unmapped;
    end
  end
endmodule

// file: verification/bwsd_decode_props.sv
`timescale 1ns/1ps
module bwsd_decode_props import bwsd_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire bwsd_req_t req,
  input wire bwsd_cfg_t cfg,
  input wire logic [11:0] site_sel,
  input wire logic rd_strobe,
  input wire logic wr_strobe,
  input wire logic blocked,
  input wire logic unmapped
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire v = req.valid;
  wire [19:0] a = req.addr;
  wire lo = v && !cfg.protect && !cfg.ram_high && cfg.ram_part == 3'h1;
  AST_ONE: assert property ($onehot0(site_sel)) else $error("sel");
  AST_NONE: assert property (unmapped |-> !site_sel) else $error("unm");
  AST_PROG: assert property (v && &a[19:18] && cfg.prog_part == BWSD_PART_64K
    |=> site_sel == 12'h1 << $past(a[17:16])) else $error("prg");
  AST_TOP: assert property (v && &a |=> site_sel == 12'h8) else $error("top");
  AST_LOW: assert property (lo && !a[19:15] |=> site_sel == 12'h10 << $past(a[14:13])) else $error("low");
  AST_HIGH: assert property (v && cfg.ram_high && !a[19:17] |=> unmapped) else $error("hi");
  AST_EXP: assert property (lo && cfg.exp_fitted && a[19:15] == 5'h1
    |=> site_sel == 12'h100 << $past(a[14:13])) else $error("exp");
  AST_PROT: assert property (v && cfg.protect && !cfg.ram_high && !a[19:13]
    |=> blocked && !site_sel) else $error("prot");
  AST_STRB: assert property (blocked |-> !rd_strobe && !wr_strobe) else $error("strobe while blocked");
  cover property (blocked);
  cover property (|site_sel[11:8]);
  cover property (unmapped);
endmodule
bind bwsd_decode bwsd_decode_props u_bwsd_decode_props (.clk, .reset, .req, .cfg, .site_sel, .rd_strobe,
  .wr_strobe, .blocked, .unmapped);

// file: verification/bwsd_host.sv
`timescale 1ns/1ps
module bwsd_host import bwsd_pkg::*; (
  input wire logic clk,
  output bwsd_req_t req
);
  initial req = 22'h0;
  // Valid drops after each cycle so every access is a fresh request
  task automatic acc(input logic w, input logic [19:0] ad);
    @(posedge clk) req <= {1'h1, w, ad};
    @(posedge clk) req <= 22'h0;
  endtask
endmodule

// file: verification/bwsd_decode_tb.sv
`timescale 1ns/1ps
module bwsd_decode_tb import bwsd_pkg::*;;
  logic clk = 0, reset = 1, rd, wr, blk, unm;
  logic [11:0] sel;
  bwsd_req_t req;
  bwsd_cfg_t cfg = 9'h0;
  int n_errors = 0, check_count = 0;
  bwsd_host u_bwsd_host (.clk, .req);
  bwsd_decode u_bwsd_decode (.clk, .reset, .req, .cfg, .site_sel(sel), .rd_strobe(rd), .wr_strobe(wr),
    .blocked(blk), .unmapped(unm));
  initial forever #12.5 clk = ~clk;
  task chk(input logic [13:0] s, e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("Error outputs exp %h seen %h", e, s);
    end
  endtask
  task go(input logic w, input logic [19:0] ad, input logic [13:0] e);
    u_bwsd_host.acc(w, ad);
    #1 chk({blk, unm, sel}, e);
  endtask
  task t_prog;
    for (int p = 0; p < 5; p++) begin
      @(posedge clk);
      cfg.prog_part <= bwsd_part_t'(p);
      go(0, 20'h0 - (p ? 20'h4000 << p : 20'h2000), 14'h1);
      go(0, 20'hFFFFF - (p ? 20'h4000 << p : 20'h2000), 14'h1000);
    end
    $display("prog done");
  endtask
  task t_data;
    @(posedge clk);
    cfg <= {BWSD_PART_64K, 3'h1, 1'h0, 1'h1, 1'h0};
    go(1, 20'h06000, 14'h80);
    chk({rd, wr}, 14'h1);
    go(0, 20'h0A000, 14'h200);
    go(0, 20'h10000, 14'h1000);
    @(posedge clk);
    cfg.protect <= 1;
    go(0, 20'h00000, 14'h2000);
    go(1, 20'h08000, 14'h2000);
    chk({rd, wr}, 14'h0);
    $display("data done");
  endtask
  task t_high;
    @(posedge clk);
    cfg <= {BWSD_PART_64K, 3'h1, 1'h1, 1'h0, 1'h0};
    go(0, 20'hBFFFF, 14'h80);
    chk({rd, wr}, 14'h2);
    go(0, 20'h00000, 14'h1000);
    $display("high done");
  endtask
  task summarize;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    reset <= 0;
    t_prog;
    t_data;
    t_high;
    summarize;
  end
  initial begin
    #20000;
    n_errors++;
    summarize;
  end
endmodule
